// >>> mio_axil_slave.sv
// AXI4-Lite slave front end that turns bus transfers into register strobes.
`timescale 1ns/1ps
module mio_axil_slave import mio_pkg::*; (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   output logic wr_en,
   output logic [7:0] wr_addr,
   output logic [31:0] wr_data,
   output logic [3:0] wr_strb,
   input wire logic wr_err,
   output logic [7:0] rd_addr,
   input wire logic [31:0] rd_data,
   input wire logic rd_err
);
   logic aw_held;
   logic w_held;

   // Address and data are parked separately so they may arrive in either order.
   assign awready = !aw_held;
   assign wready = !w_held;
   assign wr_en = aw_held && w_held && !bvalid;
   assign arready = !rvalid;
   assign rd_addr = araddr;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         wr_addr <= 8'h00;
      end else if (wr_en) begin
         aw_held <= 1'b0;
      end else if (awvalid && awready) begin
         aw_held <= 1'b1;
         wr_addr <= awaddr;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held <= 1'b0;
         wr_data <= 32'h0000_0000;
         wr_strb <= 4'h0;
      end else if (wr_en) begin
         w_held <= 1'b0;
      end else if (wvalid && wready) begin
         w_held <= 1'b1;
         wr_data <= wdata;
         wr_strb <= wstrb;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid <= 1'b0;
         bresp <= MIO_RESP_OKAY;
      end else if (wr_en) begin
         bvalid <= 1'b1;
         bresp <= wr_err ? MIO_RESP_SLVERR : MIO_RESP_OKAY;
      end else if (bready) begin
         bvalid <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= MIO_RESP_OKAY;
      end else if (arvalid && arready) begin
         rvalid <= 1'b1;
         rdata <= rd_data;
         rresp <= rd_err ? MIO_RESP_SLVERR : MIO_RESP_OKAY;
      end else if (rready) begin
         rvalid <= 1'b0;
      end
   end

   sequence s_resp_waits;
      bvalid && !bready;
   endsequence

   a_bresp_stable: assert property (@(posedge aclk) disable iff (!aresetn)
      s_resp_waits |=> bvalid && $stable(bresp))
      else $error("write response dropped before it was taken");
   a_read_latency: assert property (@(posedge aclk) disable iff (!aresetn)
      arvalid && arready |=> rvalid)
      else $error("read answer not given one cycle after address");
endmodule

// >>> mio_div2.sv
// Divide-by-two of a timer underflow pulse train.
`timescale 1ns/1ps
module mio_div2 import mio_pkg::*; (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic tick,
   output logic half
);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         half <= 1'b0;
      end else if (tick) begin
         half <= ~half;
      end
   end

   a_half_toggle: assert property (@(posedge aclk) disable iff (!aresetn)
      tick |=> half != $past(half))
      else $error("divided underflow did not toggle");
   a_half_hold: assert property (@(posedge aclk) disable iff (!aresetn)
      !tick |=> $stable(half))
      else $error("divided underflow changed without a tick");
endmodule

// >>> mio_pad_model.sv
// Board-side model of a group of port pads with an external driver on every line.
`timescale 1ns/1ps
module mio_pad_model #(parameter int W = 4) (
   input wire logic [W-1:0] o,
   input wire logic [W-1:0] n,
   input wire logic [W-1:0] e,
   output logic [W-1:0] p
);
   // A released line shows the board level and a driven line shows o, so a driven CMOS pad reads back its latch.
   assign p = (o & ~n) | (e & n);
endmodule

// >>> mio_pkg.sv
// Shared types of the port block.
package mio_pkg;
   typedef logic [31:0] mio_word_t;
   typedef logic [7:0] mio_byte_t;
   typedef logic [3:0] mio_nib_t;
   typedef enum logic [1:0] {
      MIO_RESP_OKAY = 2'h0,
      MIO_RESP_SLVERR = 2'h2
   } mio_resp_t;
endpackage

// >>> mio_ports.sv
// Multifunction parallel I/O ports with AXI4-Lite control and an interrupt.
`timescale 1ns/1ps
`include "mio_ports_cfg.svh"
module mio_ports import mio_pkg::*; (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [7:0] bitwise_io_port_in,
   output logic [7:0] bitwise_io_port_out,
   output logic [7:0] bitwise_io_port_oe_n,
   input wire logic [3:0] nibble_port_zero_in,
   output logic [3:0] nibble_port_zero_out,
   output logic [3:0] nibble_port_zero_oe_n,
   input wire logic [3:0] nibble_port_one_in,
   output logic [3:0] nibble_port_one_out,
   output logic [3:0] nibble_port_one_oe_n,
   output logic [7:0] nibble_pullup_en,
   input wire logic [2:0] input_port_two_in,
   input wire logic [3:0] nibble_port_three_in,
   output logic [3:0] nibble_port_three_out,
   output logic [3:0] nibble_port_three_oe_n,
   input wire logic [3:0] analog_shared_port_in,
   output logic [3:0] analog_shared_port_out,
   output logic [3:0] analog_shared_port_oe_n,
   input wire logic [3:0] cmos_direction_port_in,
   output logic [3:0] cmos_direction_port_out,
   output logic [3:0] cmos_direction_port_oe_n,
   input wire logic timer1_underflow,
   input wire logic timer3_underflow,
   output logic timer2_event_clk,
   output logic timer4_event_clk,
   output logic serial_clk_in,
   output logic serial_data_in,
   output logic [1:0] ext_irq_level,
   input wire logic ram_backup,
   output logic wakeup_req,
   output logic irq
);
   logic wr_en;
   logic [7:0] wr_addr;
   mio_word_t wr_data;
   logic [3:0] wr_strb;
   logic wr_err;
   logic [7:0] rd_addr;
   mio_word_t rd_data;
   logic rd_err;

   mio_byte_t bit_latch;
   logic [2:0] test_sel;
   logic [15:0] nib_latch;
   mio_nib_t cmos_latch;
   mio_nib_t port_five_direction;
   mio_nib_t pullup_enable_bits;
   mio_nib_t wakeup_enable_bits;
   logic [1:0] alt_out;
   logic [2:0] irq_status;
   logic [2:0] irq_enable;
   logic [1:0] ext_pin_q;
   logic timer1_half;
   logic timer3_half;
   logic [15:0] nib_pads;
   mio_byte_t bit_drive;
   mio_byte_t wake_pins;
   logic key_low;
   logic next_wakeup;
   logic [2:0] irq_set;
   logic [2:0] irq_clr;
   mio_word_t wr_merge;

   // Byte lanes not strobed keep the register's current contents.
   function automatic mio_word_t merge_strb(mio_word_t old, mio_word_t nw, logic [3:0] strb);
      mio_word_t r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[8*i +: 8] = nw[8*i +: 8];
         end
      end
      return r;
   endfunction

   function automatic mio_byte_t pair_expand(mio_nib_t en);
      mio_byte_t r;
      r = 8'h00;
      for (int i = 0; i < 4; i++) begin
         r[2*i] = en[i];
         r[2*i+1] = en[i];
      end
      return r;
   endfunction

   function automatic logic wr_hit(logic [7:0] ofs);
      return wr_en && (wr_addr == ofs);
   endfunction

   mio_axil_slave u_bus (
      .aclk(aclk),
      .aresetn(aresetn),
      .awaddr(s_axi_awaddr),
      .awvalid(s_axi_awvalid),
      .awready(s_axi_awready),
      .wdata(s_axi_wdata),
      .wstrb(s_axi_wstrb),
      .wvalid(s_axi_wvalid),
      .wready(s_axi_wready),
      .bresp(s_axi_bresp),
      .bvalid(s_axi_bvalid),
      .bready(s_axi_bready),
      .araddr(s_axi_araddr),
      .arvalid(s_axi_arvalid),
      .arready(s_axi_arready),
      .rdata(s_axi_rdata),
      .rresp(s_axi_rresp),
      .rvalid(s_axi_rvalid),
      .rready(s_axi_rready),
      .wr_en(wr_en),
      .wr_addr(wr_addr),
      .wr_data(wr_data),
      .wr_strb(wr_strb),
      .wr_err(wr_err),
      .rd_addr(rd_addr),
      .rd_data(rd_data),
      .rd_err(rd_err)
   );

   mio_div2 u_timer1_div (
      .aclk(aclk),
      .aresetn(aresetn),
      .tick(timer1_underflow),
      .half(timer1_half)
   );

   mio_div2 u_timer3_div (
      .aclk(aclk),
      .aresetn(aresetn),
      .tick(timer3_underflow),
      .half(timer3_half)
   );

   assign nib_pads = {analog_shared_port_in, nibble_port_three_in,
                      nibble_port_one_in, nibble_port_zero_in};

   // Each write sees the strobed merge of its target; offsets with storage and the interrupt-clear offset use it.
   always_comb begin
      wr_merge = 32'h0000_0000;
      unique case (wr_addr)
         `MIO_OFS_BIT_OUT: wr_merge = merge_strb({24'h00_0000, bit_latch}, wr_data, wr_strb);
         `MIO_OFS_BIT_TEST: wr_merge = merge_strb({25'h000_0000, test_sel, 4'h0},
                                                   wr_data, wr_strb);
         `MIO_OFS_NIB_OUT: wr_merge = merge_strb({16'h0000, nib_latch}, wr_data, wr_strb);
         `MIO_OFS_CMOS: wr_merge = merge_strb({24'h00_0000, port_five_direction, cmos_latch},
                                               wr_data, wr_strb);
         `MIO_OFS_PULL_WAKE: wr_merge = merge_strb({24'h00_0000, wakeup_enable_bits,
                                                    pullup_enable_bits}, wr_data, wr_strb);
         `MIO_OFS_ALT: wr_merge = merge_strb({30'h0000_0000, alt_out}, wr_data, wr_strb);
         `MIO_OFS_IRQ_EN: wr_merge = merge_strb({29'h0000_0000, irq_enable}, wr_data, wr_strb);
         default: wr_merge = merge_strb(32'h0000_0000, wr_data, wr_strb);
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bit_latch <= `MIO_RST_BIT_OUT;
         test_sel <= 3'h0;
      end else begin
         if (wr_hit(`MIO_OFS_BIT_OUT)) begin
            bit_latch <= wr_merge[7:0];
         end
         if (wr_hit(`MIO_OFS_BIT_TEST)) begin
            test_sel <= wr_merge[`MIO_TEST_SEL_LSB +: 3];
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         nib_latch <= `MIO_RST_NIB_OUT;
      end else if (wr_hit(`MIO_OFS_NIB_OUT)) begin
         nib_latch <= wr_merge[15:0];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cmos_latch <= `MIO_RST_CMOS;
         port_five_direction <= `MIO_RST_DIR;
      end else if (wr_hit(`MIO_OFS_CMOS)) begin
         cmos_latch <= wr_merge[3:0];
         port_five_direction <= wr_merge[`MIO_CMOS_DIR_LSB +: 4];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pullup_enable_bits <= `MIO_RST_PULL;
         wakeup_enable_bits <= `MIO_RST_WAKE;
         alt_out <= `MIO_RST_ALT;
      end else begin
         if (wr_hit(`MIO_OFS_PULL_WAKE)) begin
            pullup_enable_bits <= wr_merge[3:0];
            wakeup_enable_bits <= wr_merge[`MIO_WAKE_LSB +: 4];
         end
         if (wr_hit(`MIO_OFS_ALT)) begin
            alt_out <= wr_merge[1:0];
         end
      end
   end

   // With the timer output selected the halved underflow gates a released latch.
   always_comb begin
      bit_drive = bit_latch;
      if (alt_out[`MIO_ALT_T1]) begin
         bit_drive[`MIO_TIMER1_BIT] = bit_latch[`MIO_TIMER1_BIT] & timer1_half;
      end
      if (alt_out[`MIO_ALT_T2]) begin
         bit_drive[`MIO_TIMER2_BIT] = bit_latch[`MIO_TIMER2_BIT] & timer3_half;
      end
   end

   // Open-drain pins only ever pull low; a one in the latch lets the pad float.
   assign bitwise_io_port_out = 8'h00;
   assign bitwise_io_port_oe_n = bit_drive;
   assign nibble_port_zero_out = 4'h0;
   assign nibble_port_zero_oe_n = nib_latch[`MIO_NIB_P0_LSB +: 4];
   assign nibble_port_one_out = 4'h0;
   assign nibble_port_one_oe_n = nib_latch[`MIO_NIB_P1_LSB +: 4];
   assign nibble_port_three_out = 4'h0;
   assign nibble_port_three_oe_n = nib_latch[`MIO_NIB_P3_LSB +: 4];
   assign analog_shared_port_out = 4'h0;
   assign analog_shared_port_oe_n = nib_latch[`MIO_NIB_AN_LSB +: 4];
   assign cmos_direction_port_out = cmos_latch;
   assign cmos_direction_port_oe_n = ~port_five_direction;
   assign nibble_pullup_en = pair_expand(pullup_enable_bits);
   assign wake_pins = pair_expand(wakeup_enable_bits);

   // Alternate-function inputs are registered copies of the pads, so port reads stay live.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         timer2_event_clk <= 1'b0;
         timer4_event_clk <= 1'b0;
         serial_clk_in <= 1'b0;
         serial_data_in <= 1'b0;
         ext_irq_level <= 2'h3;
         ext_pin_q <= 2'h3;
      end else begin
         timer2_event_clk <= bitwise_io_port_in[`MIO_TIMER1_BIT];
         timer4_event_clk <= bitwise_io_port_in[`MIO_TIMER2_BIT];
         serial_clk_in <= input_port_two_in[0];
         serial_data_in <= input_port_two_in[2];
         ext_irq_level <= nibble_port_three_in[1:0];
         ext_pin_q <= nibble_port_three_in[1:0];
      end
   end

   // A grounded pin with its wakeup left enabled holds the request high while ram_backup stays high.
   assign key_low = |(wake_pins & ~{nibble_port_one_in, nibble_port_zero_in});
   assign next_wakeup = ram_backup &&
                        (key_low || |(~nibble_port_three_in[1:0] & irq_enable[1:0]));

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wakeup_req <= 1'b0;
      end else begin
         wakeup_req <= next_wakeup;
      end
   end

   assign irq_set[`MIO_IRQ_EXT0] = ext_pin_q[0] && !nibble_port_three_in[0];
   assign irq_set[`MIO_IRQ_EXT1] = ext_pin_q[1] && !nibble_port_three_in[1];
   assign irq_set[`MIO_IRQ_KEY] = next_wakeup && !wakeup_req;
   // A continuous assignment does not wake on signals read inside a function body.
   assign irq_clr = (wr_en && wr_addr == `MIO_OFS_IRQ_CLR) ? wr_merge[2:0] : 3'h0;

   // A new event in the clearing cycle survives: set is applied after clear.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_status <= `MIO_RST_IRQ;
         irq_enable <= `MIO_RST_IRQ;
      end else begin
         irq_status <= (irq_status & ~irq_clr) | irq_set;
         if (wr_hit(`MIO_OFS_IRQ_EN)) begin
            irq_enable <= wr_merge[2:0];
         end
      end
   end

   assign irq = |(irq_status & irq_enable);

   // Read-only and write-only registers accept the other access silently.
   always_comb begin
      rd_data = 32'h0000_0000;
      rd_err = 1'b0;
      unique case (rd_addr)
         `MIO_OFS_BIT_OUT: rd_data = {24'h00_0000, bit_latch};
         `MIO_OFS_BIT_IN: rd_data = {24'h00_0000, bitwise_io_port_in};
         `MIO_OFS_BIT_TEST: rd_data = {25'h000_0000, test_sel, 3'h0,
                                        bitwise_io_port_in[test_sel]};
         `MIO_OFS_NIB_OUT: rd_data = {16'h0000, nib_latch};
         `MIO_OFS_NIB_IN: rd_data = {8'h00, cmos_direction_port_in, 1'b0,
                                      input_port_two_in, nib_pads};
         `MIO_OFS_CMOS: rd_data = {24'h00_0000, port_five_direction, cmos_latch};
         `MIO_OFS_PULL_WAKE: rd_data = {24'h00_0000, wakeup_enable_bits, pullup_enable_bits};
         `MIO_OFS_ALT: rd_data = {30'h0000_0000, alt_out};
         `MIO_OFS_IRQ_STAT: rd_data = {29'h0000_0000, irq_status};
         `MIO_OFS_IRQ_CLR: rd_data = 32'h0000_0000;
         `MIO_OFS_IRQ_EN: rd_data = {29'h0000_0000, irq_enable};
         default: rd_err = 1'b1;
      endcase
   end

   always_comb begin
      unique case (wr_addr)
         `MIO_OFS_BIT_OUT, `MIO_OFS_BIT_IN, `MIO_OFS_BIT_TEST, `MIO_OFS_NIB_OUT,
         `MIO_OFS_NIB_IN, `MIO_OFS_CMOS, `MIO_OFS_PULL_WAKE, `MIO_OFS_ALT,
         `MIO_OFS_IRQ_STAT, `MIO_OFS_IRQ_CLR, `MIO_OFS_IRQ_EN: wr_err = 1'b0;
         default: wr_err = 1'b1;
      endcase
   end

   logic rst_seen;

   always_ff @(posedge aclk) begin
      rst_seen <= !aresetn;
   end

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   sequence s_bit_wr;
      wr_en && wr_addr == `MIO_OFS_BIT_OUT && wr_strb[0];
   endsequence

   sequence s_nib_wr;
      wr_en && wr_addr == `MIO_OFS_NIB_OUT && wr_strb[0] && wr_strb[1];
   endsequence

   sequence s_cmos_wr;
      wr_en && wr_addr == `MIO_OFS_CMOS && wr_strb[0];
   endsequence

   a_reset_released: assert property (rst_seen |->
      cmos_direction_port_oe_n == 4'hf && nibble_port_zero_oe_n == 4'hf &&
      analog_shared_port_oe_n == 4'hf && bitwise_io_port_oe_n == 8'hff)
      else $error("ports not released after reset");
   a_bit_latch_wr: assert property (s_bit_wr |=>
      bitwise_io_port_oe_n[5:0] == $past(wr_data[5:0]))
      else $error("bitwise latch did not take written bits");
   a_nib_od_wr: assert property (s_nib_wr |=>
      nibble_port_zero_oe_n == $past(wr_data[3:0]) &&
      nibble_port_one_oe_n == $past(wr_data[7:4]))
      else $error("nibble ports zero/one do not follow latch write");
   a_nib3_od_wr: assert property (s_nib_wr |=>
      nibble_port_three_oe_n == $past(wr_data[11:8]) &&
      analog_shared_port_oe_n == $past(wr_data[15:12]))
      else $error("port three or analog port does not follow latch write");
   a_cmos_dir_wr: assert property (s_cmos_wr |=>
      cmos_direction_port_oe_n == ~$past(wr_data[7:4]) &&
      cmos_direction_port_out == $past(wr_data[3:0]))
      else $error("cmos direction or data not applied");
   a_pullup_pairs: assert property (
      nibble_pullup_en[0] == nibble_pullup_en[1] && nibble_pullup_en[2] == nibble_pullup_en[3] &&
      nibble_pullup_en[4] == nibble_pullup_en[5] && nibble_pullup_en[6] == nibble_pullup_en[7])
      else $error("pull-up pair split");
   a_key_wakeup: assert property (
      ram_backup && wakeup_enable_bits[1] && !nibble_port_zero_in[2] |=> wakeup_req)
      else $error("key wakeup not raised");
   a_no_wake_active: assert property (!ram_backup |=> !wakeup_req)
      else $error("wakeup raised outside back-up state");
   a_ext_irq_event: assert property (
      ext_pin_q[0] && !nibble_port_three_in[0] |=> irq_status[`MIO_IRQ_EXT0])
      else $error("falling edge on first interrupt pin lost");
   a_timer_out: assert property (
      alt_out[`MIO_ALT_T1] && bit_latch[`MIO_TIMER1_BIT] && timer1_underflow
      |=> bitwise_io_port_oe_n[`MIO_TIMER1_BIT] != $past(timer1_half))
      else $error("first timer pin does not present divided underflow");
endmodule

// >>> mio_ports_cfg.svh
// Register offsets, field positions and reset values of the port block.
`ifndef MIO_PORTS_CFG_SVH
`define MIO_PORTS_CFG_SVH

`define MIO_OFS_BIT_OUT   8'h00
`define MIO_OFS_BIT_IN    8'h04
`define MIO_OFS_BIT_TEST  8'h08
`define MIO_OFS_NIB_OUT   8'h0c
`define MIO_OFS_NIB_IN    8'h10
`define MIO_OFS_CMOS      8'h14
`define MIO_OFS_PULL_WAKE 8'h18
`define MIO_OFS_ALT       8'h1c
`define MIO_OFS_IRQ_STAT  8'h20
`define MIO_OFS_IRQ_CLR   8'h24
`define MIO_OFS_IRQ_EN    8'h28

`define MIO_RST_BIT_OUT   8'hff
`define MIO_RST_NIB_OUT   16'hffff
`define MIO_RST_CMOS      4'h0
`define MIO_RST_DIR       4'h0
`define MIO_RST_PULL      4'h0
`define MIO_RST_WAKE      4'h0
`define MIO_RST_ALT       2'h0
`define MIO_RST_IRQ       3'h0

`define MIO_NIB_P0_LSB    0
`define MIO_NIB_P1_LSB    4
`define MIO_NIB_P3_LSB    8
`define MIO_NIB_AN_LSB    12
`define MIO_IN_P2_LSB     16
`define MIO_IN_CMOS_LSB   20
`define MIO_CMOS_DIR_LSB  4
`define MIO_WAKE_LSB      4
`define MIO_TEST_SEL_LSB  4

`define MIO_ALT_T1        0
`define MIO_ALT_T2        1
`define MIO_IRQ_EXT0      0
`define MIO_IRQ_EXT1      1
`define MIO_IRQ_KEY       2

`define MIO_TIMER1_BIT    6
`define MIO_TIMER2_BIT    7

`endif

// >>> multifunction_io_ports_bench.sv
// Self-checking bench of the port block driven over AXI4-Lite.
`timescale 1ns/1ps
`include "mio_ports_cfg.svh"
module multifunction_io_ports_bench import mio_pkg::*;;
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, irq;
   logic timer1_underflow, timer3_underflow, timer2_event_clk, timer4_event_clk, wakeup_req;
   logic serial_clk_in, serial_data_in, ram_backup;
   logic [7:0] s_axi_awaddr, s_axi_araddr, bitwise_io_port_in, bitwise_io_port_out, e_b;
   logic [7:0] bitwise_io_port_oe_n, nibble_pullup_en;
   logic [31:0] s_axi_wdata, s_axi_rdata, s, v;
   logic [3:0] s_axi_wstrb, nibble_port_zero_in, nibble_port_zero_out, nibble_port_zero_oe_n;
   logic [3:0] nibble_port_one_in, nibble_port_one_out, nibble_port_one_oe_n, e0, e1, e3, ea;
   logic [3:0] nibble_port_three_in, nibble_port_three_out, nibble_port_three_oe_n, ec;
   logic [3:0] analog_shared_port_in, analog_shared_port_out, analog_shared_port_oe_n;
   logic [3:0] cmos_direction_port_in, cmos_direction_port_out, cmos_direction_port_oe_n;
   logic [2:0] input_port_two_in;
   logic [1:0] s_axi_bresp, s_axi_rresp, ext_irq_level;
   logic [33:0] exq[$];
   logic [1:0] bq[$];
   int bad_count = 0;
   int checked = 0;
   int cyc = 0;
   mio_ports dut (.*);
   mio_pad_model #(.W(8)) pb (.o(bitwise_io_port_out), .n(bitwise_io_port_oe_n), .e(e_b),
      .p(bitwise_io_port_in));
   mio_pad_model p0 (.o(nibble_port_zero_out), .n(nibble_port_zero_oe_n), .e(e0),
      .p(nibble_port_zero_in));
   mio_pad_model p1 (.o(nibble_port_one_out), .n(nibble_port_one_oe_n), .e(e1),
      .p(nibble_port_one_in));
   mio_pad_model p3 (.o(nibble_port_three_out), .n(nibble_port_three_oe_n), .e(e3),
      .p(nibble_port_three_in));
   mio_pad_model pa (.o(analog_shared_port_out), .n(analog_shared_port_oe_n), .e(ea),
      .p(analog_shared_port_in));
   mio_pad_model pc (.o(cmos_direction_port_out), .n(cmos_direction_port_oe_n), .e(ec),
      .p(cmos_direction_port_in));
   initial begin
      aclk = 0;
      forever #12.5 aclk = ~aclk;
   end
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   task report_and_stop;
      $display("comparisons %0d, mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task chk(input string nm, input logic [33:0] ex, input logic [33:0] got);
      checked++;
      if (got !== ex) begin
         bad_count++;
         $display("unexpected %s: expected %h, seen %h", nm, ex, got);
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] eb = 2'h0);
      logic ta;
      logic tw;
      ta = 0;
      tw = 0;
      bq.push_back(eb);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      while (!(ta && tw)) begin
         @(posedge aclk);
         ta = ta | s_axi_awready;
         tw = tw | s_axi_wready;
         if (ta) s_axi_awvalid <= 0;
         if (tw) s_axi_wvalid <= 0;
      end
      // Ready stays high, so a following call never lowers and raises it in one step.
      do @(posedge aclk); while (!s_axi_bvalid);
   endtask
   // The expected word is queued before the request, so the watcher always finds it.
   task rd(input logic [7:0] a, input logic [33:0] ex);
      exq.push_back(ex);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 0;
      do @(posedge aclk); while (!s_axi_rvalid);
   endtask
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (s_axi_rvalid && s_axi_rready)
         chk("read word", exq.pop_front(), {s_axi_rresp, s_axi_rdata});
      if (s_axi_bvalid && s_axi_bready) chk("write resp", bq.pop_front(), s_axi_bresp);
      if (cyc == 3000) begin
         bad_count++;
         report_and_stop();
      end
   end
   initial begin
      s = 32'h0001_0d8d;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {timer1_underflow, timer3_underflow, ram_backup, aresetn} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      {e_b, e0, e1, e3, ea, ec} = '1;
      s_axi_wstrb = 4'hf;
      input_port_two_in = 3'h5;
      repeat (6) @(posedge aclk);
      aresetn <= 1;
      @(posedge aclk);
      chk("released pins", 28'hfff_ffff, {bitwise_io_port_oe_n, nibble_port_zero_oe_n,
         nibble_port_one_oe_n, nibble_port_three_oe_n, analog_shared_port_oe_n,
         cmos_direction_port_oe_n});
      rd(`MIO_OFS_BIT_OUT, 34'h0_0000_00ff);
      rd(`MIO_OFS_NIB_OUT, 34'h0_0000_ffff);
      rd(`MIO_OFS_CMOS, 34'h0);
      for (int i = 0; i < 4; i++) begin
         s = lfsr(s);
         v = lfsr(s);
         e_b <= s[7:0];
         {ea, e3, e1, e0} <= s[31:16];
         input_port_two_in <= s[10:8];
         wr(`MIO_OFS_BIT_OUT, {24'h00_0000, s[15:8]});
         wr(`MIO_OFS_NIB_OUT, v);
         wr(`MIO_OFS_BIT_TEST, {25'h000_0000, s[18:16], 4'h0});
         rd(`MIO_OFS_BIT_IN, {26'h000_0000, s[15:8] & s[7:0]});
         rd(`MIO_OFS_BIT_TEST, {27'h0, s[18:16], 3'h0, s[s[18:16] + 8] & s[s[18:16]]});
         v = {8'h00, ec, 1'h0, s[10:8], v[15:0] & s[31:16]};
         rd(`MIO_OFS_NIB_IN, {2'h0, v});
      end
      wr(`MIO_OFS_CMOS, 32'h0000_00f5);
      chk("cmos drive", 8'h05, {cmos_direction_port_oe_n, cmos_direction_port_out});
      {e_b, e0, e1, e3, ea} <= '1;
      wr(`MIO_OFS_NIB_OUT, 32'h0000_ffff);
      wr(`MIO_OFS_BIT_OUT, 32'h0000_00ff);
      ram_backup <= 1;
      wr(`MIO_OFS_PULL_WAKE, 32'h0000_0024);
      chk("pull-ups", 8'h30, nibble_pullup_en);
      e0 <= 4'he;
      repeat (3) @(posedge aclk);
      chk("wake off pair", 1'h0, wakeup_req);
      e0 <= 4'hb;
      repeat (3) @(posedge aclk);
      chk("wake on pair", 1'h1, wakeup_req);
      ram_backup <= 0;
      e0 <= 4'hf;
      wr(`MIO_OFS_IRQ_CLR, 32'h0000_0007);
      wr(`MIO_OFS_IRQ_EN, 32'h0000_0001);
      e3 <= 4'he;
      repeat (3) @(posedge aclk);
      chk("irq raised", 1'h1, irq);
      chk("irq level", 2'h2, ext_irq_level);
      rd(`MIO_OFS_IRQ_STAT, 34'h1);
      wr(`MIO_OFS_IRQ_EN, 32'h0000_0000);
      chk("irq masked", 1'h0, irq);
      wr(`MIO_OFS_IRQ_CLR, 32'h0000_0001);
      wr(`MIO_OFS_IRQ_EN, 32'h0000_0001);
      chk("irq cleared", 1'h0, irq);
      rd(8'h3c, 34'h2_0000_0000);
      wr(8'h3c, 32'h0000_0000, 2'h2);
      wr(`MIO_OFS_ALT, 32'h0000_0003);
      chk("timer idle", 2'h0, bitwise_io_port_oe_n[7:6]);
      {timer1_underflow, timer3_underflow} <= 2'h3;
      @(posedge aclk);
      {timer1_underflow, timer3_underflow} <= 2'h0;
      repeat (3) @(posedge aclk);
      chk("timer out", 2'h3, bitwise_io_port_oe_n[7:6]);
      chk("event clk", 2'h3, {timer4_event_clk, timer2_event_clk});
      chk("serial", {s[10], s[8]}, {serial_data_in, serial_clk_in});
      report_and_stop();
   end
endmodule
